/* lisst_top.v */
// lisst_top.v: lane inversion shift registers for two memory channel ports
// assumes a plain register port and loop-end pulses from the self-test engine
`timescale 1ns/1ps
`include "lisst_defines.vh"

module lisst_top (
	input wire REF_CLK,
	input wire RSTN,
	input wire WARM_RSTN,
	input wire [11:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [31:0] RDATA,
	input wire [1:0] RUN,
	input wire [1:0] LOOP_END,
	input wire [1:0] RX_INVERT_SWAP_MODE,
	input wire [13:0] TX_PAT_A,
	input wire [13:0] TX_PAT_B,
	output wire [13:0] TX_LANE_A,
	output wire [13:0] TX_LANE_B,
	input wire [13:0] RX_EXP_A,
	input wire [13:0] RX_EXP_B,
	input wire [13:0] RX_LANE_A,
	input wire [13:0] RX_LANE_B,
	output wire [13:0] RX_MISMATCH_A,
	output wire [13:0] RX_MISMATCH_B
);
	wire [13:0] tx_a_reg;
	wire [13:0] tx_b_reg;
	wire [13:0] rx_a_reg;
	wire [13:0] rx_b_reg;
	wire wr_tx_a;
	wire wr_tx_b;
	wire wr_rx_a;
	wire wr_rx_b;
	reg [31:0] rdata_next;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// upper write bits are dropped, so reserved bits stay zero
	assign wr_tx_a = WR && (ADDR == `LISST_TX_A_OFF);
	assign wr_tx_b = WR && (ADDR == `LISST_TX_B_OFF);
	assign wr_rx_a = WR && (ADDR == `LISST_RX_A_OFF);
	assign wr_rx_b = WR && (ADDR == `LISST_RX_B_OFF);

	// ----------------------------------------
	// port instances
	// ----------------------------------------
	lisst_tx_shift u_tx_a (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.warm_rst_n(WARM_RSTN),
		.wr_en(wr_tx_a),
		.wr_data(WDATA[13:0]),
		.run(RUN[0]),
		.loop_end(LOOP_END[0]),
		.pattern_in(TX_PAT_A),
		.pattern_out(TX_LANE_A),
		.pat_reg(tx_a_reg)
	);

	lisst_tx_shift u_tx_b (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.warm_rst_n(WARM_RSTN),
		.wr_en(wr_tx_b),
		.wr_data(WDATA[13:0]),
		.run(RUN[1]),
		.loop_end(LOOP_END[1]),
		.pattern_in(TX_PAT_B),
		.pattern_out(TX_LANE_B),
		.pat_reg(tx_b_reg)
	);

	lisst_rx_shift u_rx_a (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.warm_rst_n(WARM_RSTN),
		.wr_en(wr_rx_a),
		.wr_data(WDATA[13:0]),
		.run(RUN[0]),
		.loop_end(LOOP_END[0]),
		.swap_mode(RX_INVERT_SWAP_MODE[0]),
		.pattern_in(RX_EXP_A),
		.lane_data(RX_LANE_A),
		.lane_mismatch(RX_MISMATCH_A),
		.pat_reg(rx_a_reg)
	);

	lisst_rx_shift u_rx_b (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.warm_rst_n(WARM_RSTN),
		.wr_en(wr_rx_b),
		.wr_data(WDATA[13:0]),
		.run(RUN[1]),
		.loop_end(LOOP_END[1]),
		.swap_mode(RX_INVERT_SWAP_MODE[1]),
		.pattern_in(RX_EXP_B),
		.lane_data(RX_LANE_B),
		.lane_mismatch(RX_MISMATCH_B),
		.pat_reg(rx_b_reg)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// unmapped addresses read zero
	always @* begin
		rdata_next = 32'h0000_0000;
		if (RD) begin
			case (ADDR)
			`LISST_TX_A_OFF: rdata_next = {18'h0_0000, tx_a_reg};
			`LISST_TX_B_OFF: rdata_next = {18'h0_0000, tx_b_reg};
			`LISST_RX_A_OFF: rdata_next = {18'h0_0000, rx_a_reg};
			`LISST_RX_B_OFF: rdata_next = {18'h0_0000, rx_b_reg};
			default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge REF_CLK) begin
		if (!RSTN) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= rdata_next;
		end
	end
endmodule

/* lisst_defines.vh */
// lisst_defines.vh: offsets, field positions, reset values for lane inversion
// assumes inclusion by the lane inversion self-test design files only
`ifndef LISST_DEFINES_VH
`define LISST_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LISST_TX_A_OFF 12'h0194
`define LISST_RX_A_OFF 12'h0198
`define LISST_TX_B_OFF 12'h0294
`define LISST_RX_B_OFF 12'h0298
`define LISST_AW 12

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define LISST_TX_MAIN_W 10
`define LISST_TX_EXT_W 4
`define LISST_PAT_W 14
`define LISST_TX_MAIN_RST 10'h001
`define LISST_TX_EXT_RST 4'h0
`define LISST_RX_LO_RST 13'h0001
`define LISST_RX_HI_RST 1'b0
`define LISST_RX_SUB 5

`endif

/* lisst_tx_shift.v */
// lisst_tx_shift.v: transmit inversion pattern register for one port
// assumes loop_end is a one-cycle pulse from the self-test loop counter
`timescale 1ns/1ps
`include "lisst_defines.vh"

module lisst_tx_shift (
	input wire clk,
	input wire rst_n,
	input wire warm_rst_n,
	input wire wr_en,
	input wire [13:0] wr_data,
	input wire run,
	input wire loop_end,
	input wire [13:0] pattern_in,
	output wire [13:0] pattern_out,
	output reg [13:0] pat_reg
);
	reg [13:0] pat_next;

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	// software write wins over a shift in the same cycle
	always @* begin
		pat_next = pat_reg;
		if (wr_en) begin
			pat_next = wr_data;
		end else if (run && loop_end) begin
			pat_next[9:0] = {pat_reg[8:0], 1'b0};
			pat_next[13:10] = {pat_reg[12:10], 1'b0};
		end
	end

	// sticky: only the cold reset clears, warm reset keeps the value
	always @(posedge clk) begin
		if (!rst_n) begin
			pat_reg <= {`LISST_TX_EXT_RST, `LISST_TX_MAIN_RST};
		end else if (warm_rst_n) begin
			pat_reg <= pat_next;
		end
	end

	assign pattern_out = pattern_in ^ pat_reg;
endmodule

/* lisst_rx_shift.v */
// lisst_rx_shift.v: receive inversion rotate register and expected data
// assumes loop_end is a one-cycle pulse from the self-test loop counter
`timescale 1ns/1ps
`include "lisst_defines.vh"

module lisst_rx_shift (
	input wire clk,
	input wire rst_n,
	input wire warm_rst_n,
	input wire wr_en,
	input wire [13:0] wr_data,
	input wire run,
	input wire loop_end,
	input wire swap_mode,
	input wire [13:0] pattern_in,
	input wire [13:0] lane_data,
	output wire [13:0] lane_mismatch,
	output reg [13:0] pat_reg
);
	reg [13:0] pat_next;
	reg [13:0] sub_sel;
	integer i;

	// ----------------------------------------
	// rotate register
	// ----------------------------------------
	// swap_mode is deliberately not read here
	always @* begin
		pat_next = pat_reg;
		if (wr_en) begin
			pat_next = wr_data;
		end else if (run && loop_end) begin
			pat_next = {pat_reg[12:0], pat_reg[13]};
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			pat_reg <= {`LISST_RX_HI_RST, `LISST_RX_LO_RST};
		end else if (warm_rst_n) begin
			pat_reg <= pat_next;
		end
	end

	// ----------------------------------------
	// per-subsection compare, pattern index modulo five
	// ----------------------------------------
	// lane i uses pattern bit (i mod 5): each five-lane group sees the same
	// inversion, so a walking bit in pattern bits 0-3 covers all three subsections at once, bit 4 only lanes 4 and 9
	always @* begin
		sub_sel = 14'h0000;
		for (i = 0; i < 14; i = i + 1) begin
			sub_sel[i] = pat_reg[i % `LISST_RX_SUB];
		end
	end

	assign lane_mismatch = lane_data ^ (pattern_in ^ sub_sel);
endmodule

/* lisst_buf_model.sv */
// far-side buffer model: returns northbound lane data
// assumes the bench picks inversion and injected errors
`timescale 1ns/1ps
module lisst_buf_model (
	input wire [13:0] data,
	input wire [13:0] inv,
	input wire [13:0] err,
	output wire [13:0] lane
);
	// err flips lanes on purpose, as a faulty link would
	assign lane = data ^ inv ^ err;
endmodule

/* lisst_top_assertions.sv */
// port checks for the lane inversion block
// assumes bind onto lisst_top, single clock domain
`timescale 1ns/1ps
module lisst_chk (
	input wire REF_CLK,
	input wire RSTN,
	input wire WARM_RSTN,
	input wire WR,
	input wire RD,
	input wire [31:0] RDATA,
	input wire [1:0] RUN,
	input wire [1:0] LOOP_END,
	input wire [13:0] TX_PAT_A,
	input wire [13:0] TX_LANE_A,
	input wire [13:0] RX_EXP_A,
	input wire [13:0] RX_LANE_A,
	input wire [13:0] RX_MISMATCH_A
);
	// mask recovered from the lanes, pattern cancels out
	wire [13:0] ma = TX_LANE_A ^ TX_PAT_A;
	wire [13:0] sa = RX_MISMATCH_A ^ RX_LANE_A ^ RX_EXP_A;
	wire sh = RUN[0] && LOOP_END[0] && !WR && WARM_RSTN;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	chk_rd_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("rdata not zero");
	chk_rd_resv: assert property (RDATA[31:14] == 18'h0)
		else $error("reserved bits set");
	chk_rst_tx: assert property ($rose(RSTN) |-> ma == 14'h0001)
		else $error("tx reset mask");
	chk_rst_rx: assert property ($rose(RSTN) |-> sa == 14'h0421)
		else $error("rx reset select");
	chk_tx_shift: assert property (sh |=>
		ma == {$past(ma[12:10]), 1'b0, $past(ma[8:0]), 1'b0})
		else $error("tx shift wrong");
	chk_tx_hold: assert property (!WR && !LOOP_END[0] |=> $stable(ma))
		else $error("tx mask moved");
	chk_rx_hold: assert property (!WR && !LOOP_END[0] |=> $stable(sa))
		else $error("rx select moved");
	chk_warm_hold: assert property (!WARM_RSTN |=> $stable(ma))
		else $error("sticky lost");
endmodule
bind lisst_top lisst_chk u_chk (.REF_CLK, .RSTN, .WARM_RSTN, .WR, .RD,
	.RDATA, .RUN, .LOOP_END, .TX_PAT_A, .TX_LANE_A, .RX_EXP_A, .RX_LANE_A,
	.RX_MISMATCH_A);

/* tb.sv */
// register, shift and compare tests for the lane inversion block
// assumes lisst_top, lisst_chk and lisst_buf_model compiled first
`timescale 1ns/1ps
module tb;
	reg clk = 0, rstn = 0, wrn = 1, wr = 0, rd = 0;
	reg [11:0] addr = 0;
	reg [31:0] wd = 0;
	reg [1:0] run = 0, le = 0, swp = 0;
	reg [13:0] tp = 14'h1234, ex = 14'h0abc, inv = 14'h0421, err = 0;
	wire [31:0] rdata;
	wire [13:0] tla, rla, rma, tlb, rmb;
	integer error_cnt = 0, checks_done = 0, cyc = 0, i;
	// rows: address, write data (zero means read only), read-back
	reg [11:0] ra [0:6] = '{12'h194, 12'h198, 12'h294, 12'h298,
		12'h194, 12'h298, 12'h190};
	reg [31:0] rw [0:6] = '{0, 0, 0, 0, 32'hffff_ffff, 32'hffff_2aaa,
		32'hffff_ffff};
	reg [31:0] rx [0:6] = '{1, 1, 1, 1, 32'h3fff, 32'h2aaa, 0};
	always #50 clk = ~clk;
	lisst_buf_model u_buf (.data(ex), .inv(inv), .err(err), .lane(rla));
	lisst_top u_dut (.REF_CLK(clk), .RSTN(rstn), .WARM_RSTN(wrn),
		.ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata),
		.RUN(run), .LOOP_END(le), .RX_INVERT_SWAP_MODE(swp),
		.TX_PAT_A(tp), .TX_PAT_B(tp), .TX_LANE_A(tla), .TX_LANE_B(tlb),
		.RX_EXP_A(ex), .RX_EXP_B(ex), .RX_LANE_A(rla), .RX_LANE_B(ex),
		.RX_MISMATCH_A(rma), .RX_MISMATCH_B(rmb));
	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s exp %h got %h", n, e, g);
			end
		end
	endtask
	task wt(input [11:0] a, input [31:0] d);
		begin
			@(posedge clk);
			wr <= 1;
			addr <= a;
			wd <= d;
			@(posedge clk);
			wr <= 0;
		end
	endtask
	task rt(input [11:0] a, input [31:0] e);
		begin
			@(posedge clk);
			rd <= 1;
			addr <= a;
			@(posedge clk);
			rd <= 0;
			#1 chk("rdata", e, rdata);
		end
	endtask
	// one completed loop on the ports selected by p while they run
	task lp(input [1:0] p);
		begin
			@(posedge clk);
			run <= p;
			le <= p;
			@(posedge clk);
			le <= 2'b00;
		end
	endtask
	task results;
		begin
			$display("errors %0d checks %0d", error_cnt, checks_done);
			if (error_cnt == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// a hang costs a mismatch, limit well above the run length
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			error_cnt = error_cnt + 1;
			results;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1;
		for (i = 0; i < 7; i = i + 1) begin
			if (rw[i] != 0) wt(ra[i], rw[i]);
			rt(ra[i], rx[i]);
		end
		// port B: tx walks 0x001 to 0x002, rx 0x2aaa rotates to 0x1555
		lp(2'b10);
		rt(12'h294, 32'h0000_0002);
		rt(12'h298, 32'h0000_1555);
		chk("tx_lane_b", {18'h0, tp ^ 14'h0002}, {18'h0, tlb});
		chk("mismatch_b", 32'h0000_16b5, {18'h0, rmb});
		wt(12'h194, 32'h0000_2201);
		lp(2'b01);
		rt(12'h194, 32'h0000_0002);
		chk("tx_lane", {18'h0, tp ^ 14'h0002}, {18'h0, tla});
		@(posedge clk);
		swp <= 2'b11;
		wt(12'h198, 32'h0000_2004);
		lp(2'b01);
		rt(12'h198, 32'h0000_0009);
		// far side inverts lanes 0,3,5,8,10,13 for pattern bits 0 and 3
		@(posedge clk);
		err <= 14'h0010;
		inv <= 14'h2529;
		@(posedge clk);
		#1 chk("mismatch", 32'h0000_0010, {18'h0, rma});
		@(posedge clk);
		wrn <= 0;
		wt(12'h194, 32'h0000_03ff);
		lp(2'b01);
		wrn <= 1;
		rt(12'h194, 32'h0000_0004);
		// cold reset in mid-run brings back the reset values
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		rt(12'h194, 32'h0000_0001);
		rt(12'h198, 32'h0000_0001);
		results;
	end
endmodule
